// File: darr_pkg.sv
/*
 * Shared constants and carrier types for the acceleration read responder:
 * command codes, register offsets, field positions, reset values and the
 * request and response carriers.
 * Assumes frame decoding and frame check are handled outside this block.
 */
`default_nettype none
package darr_pkg;
    localparam logic [3:0] CMD_INIT = 4'h0;
    localparam logic [3:0] CMD_ACCEL = 4'h2;
    localparam logic [3:0] CMD_UNIMPL = 4'h3;
    localparam logic [3:0] ADDR_GLOBAL = 4'h0;
    localparam logic [4:0] LEN_LONG = 5'h10;
    localparam logic [4:0] LEN_SHORT8 = 5'h08;
    localparam logic [4:0] LEN_SHORT9 = 5'h09;
    localparam logic [4:0] LEN_FULL = 5'h0a;
    localparam logic [4:0] LEN_MAX = 5'h10;
    localparam logic [9:0] ACC_ERROR = 10'h000;
    localparam logic [9:0] ACC_MIN = 10'h001;
    localparam logic [9:0] ACC_ZERO_G = 10'h200;
    localparam int ERR_POS = 10;
    localparam int ST_POS = 12;
    localparam int AT_POS = 13;
    localparam int ADDR_POS = 12;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CFG = 8'h04;
    localparam logic [7:0] REG_ACC = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0c;
    localparam logic [7:0] REG_LAST = 8'h10;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] ACC_RESET = 32'h0000_0200;

    typedef enum logic [1:0] {
        DARR_STD_LONG,
        DARR_STD_SHORT,
        DARR_ENH_LONG,
        DARR_ENH_SHORT
    } darr_fmt_type;

    typedef struct packed {
        logic [7:0] data;
        logic [3:0] addr;
        logic [3:0] cmd;
        darr_fmt_type fmt;
        logic [4:0] len;
    } darr_req_type;

    typedef struct packed {
        logic [15:0] bits;
        logic [4:0] len;
    } darr_rsp_type;
endpackage
`default_nettype wire

// File: darr_accel_fmt.sv
/*
 * Builds the acceleration read response word from the sample and flags.
 * Assumes the sample is ten-bit offset binary and the length is 8 to 16.
 */
`default_nettype none
module darr_accel_fmt (
    // Sample and flags.
    input wire logic [9:0] sample,
    input wire logic err_flag,
    input wire logic st_flag,
    input wire logic [1:0] attr,
    input wire logic [3:0] addr,
    // Frame shape.
    input wire logic long_fmt,
    input wire logic [4:0] len,
    // Response bits, low aligned.
    output logic [15:0] word
);
    import darr_pkg::*;

    logic [7:0] t8;
    logic [8:0] t9;
    logic [15:0] full;
    logic [15:0] mask;

    always_comb begin
        // Low bits are dropped; a zero after truncation of valid data becomes one.
        t8 = sample[9:2];
        t9 = sample[9:1];
        if (sample != ACC_ERROR && t8 == 8'h00) begin
            t8 = 8'h01;
        end
        if (sample != ACC_ERROR && t9 == 9'h000) begin
            t9 = 9'h001;
        end
        // Upward from the result: error, zero, self-test, attribute 0, attribute 1, zero.
        full = {1'b0, attr, st_flag, 1'b0, err_flag, sample};
        mask = 16'hffff >> (5'(LEN_MAX) - len);
        if (long_fmt) begin
            word = {addr, 1'b0, err_flag, sample};
        end else if (len == LEN_SHORT8) begin
            word = {8'h00, t8};
        end else if (len == LEN_SHORT9) begin
            word = {7'h00, t9};
        end else if (len < LEN_SHORT8) begin
            word = 16'h0000;
        end else begin
            word = full & mask;
        end
    end
endmodule // darr_accel_fmt
`default_nettype wire

// File: darr_ahb_regs.sv
/*
 * AHB-Lite slave for the responder's registers: control, configuration,
 * the acceleration sample, status and the last response.
 * Assumes single word transfers; the slave answers with zero wait states.
 */
`default_nettype none
module darr_ahb_regs (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Register contents and status.
    output logic [31:0] ctrl_ff,
    output logic [31:0] cfg_ff,
    output logic [31:0] acc_ff,
    input wire logic [31:0] stat_val,
    input wire logic [31:0] last_val
);
    import darr_pkg::*;

    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic take;

    assign take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
        end else begin
            wr_pend_ff <= take && hwrite;
            wr_addr_ff <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= CTRL_RESET;
            cfg_ff <= CFG_RESET;
            acc_ff <= ACC_RESET;
        end else if (wr_pend_ff) begin
            case (wr_addr_ff)
                REG_CTRL: ctrl_ff <= hwdata;
                REG_CFG: cfg_ff <= hwdata;
                REG_ACC: acc_ff <= hwdata;
                default: ;
            endcase
        end
    end

    // Read data is registered so it stands during the data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            case (haddr[7:0])
                REG_CTRL: hrdata <= ctrl_ff;
                REG_CFG: hrdata <= cfg_ff;
                REG_ACC: hrdata <= acc_ff;
                REG_STAT: hrdata <= stat_val;
                REG_LAST: hrdata <= last_val;
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule // darr_ahb_regs
`default_nettype wire

// File: darr_responder.sv
/*
 * Acceleration read command handler: takes a decoded request frame,
 * decides whether to answer, and issues the response word with its length.
 * Assumes framing and frame check are done outside and that each request
 * arrives as a one-cycle strobe with its fields. Software sets the sample,
 * the flags and the enhanced format enable over AHB-Lite.
 */
`default_nettype none
module darr_responder (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Request from the frame decoder.
    input wire logic req_valid,
    input wire darr_pkg::darr_req_type req,
    // Response to the frame encoder.
    output logic rsp_valid,
    output darr_pkg::darr_rsp_type rsp,
    // Device state.
    output logic [3:0] programmed_slave_address
);
    import darr_pkg::*;

    logic [31:0] ctrl_ff;
    logic [31:0] device_config_reg;
    logic [31:0] acc_ff;
    logic [31:0] stat_val;
    logic [31:0] last_val;
    logic [3:0] addr_ff;
    logic rsp_valid_ff;
    darr_rsp_type rsp_ff;
    logic [15:0] ans_cnt_ff;
    logic [15:0] ign_cnt_ff;
    logic [15:0] word;
    logic enh_en;
    logic err_flag;
    logic self_test_active_flag;
    logic [1:0] attribute_bits;
    logic fmt_ok;
    logic is_long;
    logic answer;
    logic init_ok;

    // Control: bit 0 enhanced formats, bit 1 internal fault, bit 2 self-test.
    assign enh_en = ctrl_ff[0];
    assign err_flag = ctrl_ff[1];
    assign self_test_active_flag = ctrl_ff[2];
    assign attribute_bits = device_config_reg[1:0];

    function automatic logic fmt_allowed(input darr_fmt_type f, input logic en);
        case (f)
            DARR_STD_LONG, DARR_STD_SHORT: fmt_allowed = 1'b1;
            default: fmt_allowed = en;
        endcase
    endfunction

    assign fmt_ok = fmt_allowed(req.fmt, enh_en);
    assign is_long = (req.fmt == DARR_STD_LONG) || (req.fmt == DARR_ENH_LONG);
    // Address match excludes the global address; data bits are never looked at.
    assign answer = req_valid && fmt_ok && req.cmd == CMD_ACCEL
        && addr_ff != ADDR_GLOBAL && req.addr == addr_ff;
    assign init_ok = req_valid && fmt_ok && req.cmd == CMD_INIT
        && addr_ff == ADDR_GLOBAL && req.addr != ADDR_GLOBAL;

    darr_ahb_regs u_regs (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .ctrl_ff(ctrl_ff),
        .cfg_ff(device_config_reg),
        .acc_ff(acc_ff),
        .stat_val(stat_val),
        .last_val(last_val)
    );

    darr_accel_fmt u_fmt (
        .sample(acc_ff[9:0]),
        .err_flag(err_flag),
        .st_flag(self_test_active_flag),
        .attr(attribute_bits),
        .addr(addr_ff),
        .long_fmt(is_long),
        .len(is_long ? LEN_LONG : req.len),
        .word(word)
    );

    // Slave address assignment.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_ff <= ADDR_GLOBAL;
        end else if (init_ok) begin
            addr_ff <= req.addr;
        end
    end

    // Response strobe and word.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rsp_valid_ff <= 1'b0;
            rsp_ff <= '0;
        end else begin
            rsp_valid_ff <= answer;
            if (answer) begin
                rsp_ff.bits <= word;
                rsp_ff.len <= is_long ? LEN_LONG : req.len;
            end
        end
    end

    // Counters of answered and silently dropped acceleration read requests.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ans_cnt_ff <= 16'h0000;
            ign_cnt_ff <= 16'h0000;
        end else if (answer) begin
            ans_cnt_ff <= ans_cnt_ff + 16'h0001;
        end else if (req_valid && req.cmd == CMD_ACCEL) begin
            ign_cnt_ff <= ign_cnt_ff + 16'h0001;
        end
    end

    assign stat_val = {ign_cnt_ff[11:0], ans_cnt_ff[11:0], 4'h0, addr_ff};
    assign last_val = {11'h000, rsp_ff.len, rsp_ff.bits};
    assign rsp_valid = rsp_valid_ff;
    assign rsp = rsp_ff;
    assign programmed_slave_address = addr_ff;

    // The response is built from the previous cycle's state, so checks look one cycle back.
    answer_addr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rsp_valid |-> $past(req.addr) == addr_ff && addr_ff != ADDR_GLOBAL)
        else $error("response for foreign address");
    answer_next_a: assert property (@(posedge hclk) disable iff (!hresetn)
        answer |=> rsp_valid)
        else $error("accepted request not answered");
    global_silent_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(addr_ff) == ADDR_GLOBAL |-> !rsp_valid)
        else $error("unaddressed device answered");
    cmd_accel_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rsp_valid |-> $past(req.cmd) == CMD_ACCEL)
        else $error("answer to wrong command");
    unimpl_a: assert property (@(posedge hclk) disable iff (!hresetn)
        req_valid && req.cmd == CMD_UNIMPL |=> !rsp_valid && $stable(addr_ff))
        else $error("command 3 had an effect");
    fmt_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
        req_valid && !enh_en && (req.fmt == DARR_ENH_LONG || req.fmt == DARR_ENH_SHORT)
        |=> !rsp_valid)
        else $error("enhanced format answered while disabled");
    long_layout_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rsp_valid && rsp.len == LEN_LONG |-> rsp.bits[15:12] == addr_ff && !rsp.bits[11]
        && rsp.bits[9:0] == $past(acc_ff[9:0]))
        else $error("long layout wrong");
    short8_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rsp_valid && rsp.len == LEN_SHORT8 && $past(acc_ff[9:2]) != 8'h00 |->
        rsp.bits == {8'h00, $past(acc_ff[9:2])})
        else $error("8-bit short wrong");
    short9_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rsp_valid && rsp.len == LEN_SHORT9 && $past(acc_ff[9:1]) != 9'h000 |->
        rsp.bits == {7'h00, $past(acc_ff[9:1])})
        else $error("9-bit short wrong");
    no_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rsp_valid && rsp.len == LEN_SHORT8 && $past(acc_ff[9:0]) != ACC_ERROR |->
        rsp.bits[7:0] != 8'h00)
        else $error("zero sent for valid sample");
    no_zero9_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rsp_valid && rsp.len == LEN_SHORT9 && $past(acc_ff[9:0]) != ACC_ERROR |->
        rsp.bits[8:0] != 9'h000)
        else $error("zero sent for valid 9-bit sample");
    error_code_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rsp_valid && rsp.len < LEN_FULL && $past(acc_ff[9:0]) == ACC_ERROR |->
        rsp.bits == 16'h0000)
        else $error("error code not passed as zero");
    full_result_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rsp_valid && rsp.len >= LEN_FULL |-> rsp.bits[9:0] == $past(acc_ff[9:0]))
        else $error("full result wrong");
    gap_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rsp_valid && rsp.len > 5'h0b && rsp.len != LEN_LONG |-> !rsp.bits[11])
        else $error("gap bit not zero");
    len_match_a: assert property (@(posedge hclk) disable iff (!hresetn)
        answer && !is_long |=> rsp_valid && rsp.len == $past(req.len))
        else $error("length not matched");
    long_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
        answer && is_long |=> rsp.len == LEN_LONG)
        else $error("long length wrong");
    pad_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rsp_valid && rsp.len >= LEN_SHORT8 && rsp.len != LEN_LONG |->
        (rsp.bits >> rsp.len) == 16'h0000)
        else $error("bits beyond length not zero");
    error_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rsp_valid && rsp.len >= 5'h0b |-> rsp.bits[ERR_POS] == $past(err_flag))
        else $error("error flag wrong");
    self_test_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rsp_valid && rsp.len > 5'h0c && rsp.len != LEN_LONG |->
        rsp.bits[ST_POS] == $past(self_test_active_flag))
        else $error("self-test flag wrong");
    attr_bits_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rsp_valid && rsp.len == 5'h0f |-> rsp.bits[AT_POS +: 2] == $past(attribute_bits))
        else $error("attribute bits wrong");
    init_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        req_valid && req.cmd == CMD_INIT && req.addr == ADDR_GLOBAL |=> $stable(addr_ff))
        else $error("address zero assigned");
    init_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        init_ok |=> addr_ff == $past(req.addr))
        else $error("address not assigned");

    long_cov: cover property (@(posedge hclk) rsp_valid && rsp.len == LEN_LONG);
    short9_cov: cover property (@(posedge hclk) rsp_valid && rsp.len == LEN_SHORT9);
    short15_cov: cover property (@(posedge hclk) rsp_valid && rsp.len == 5'h0f);
    enh_cov: cover property (@(posedge hclk) answer && req.fmt == DARR_ENH_SHORT);
    err_code_cov: cover property (@(posedge hclk) rsp_valid && rsp.len == LEN_SHORT8
        && rsp.bits == 16'h0000);
endmodule // darr_responder
`default_nettype wire

// File: darr_dsi_master.sv
/*
 * Model of the sensor bus master: issues decoded request frames to the
 * responder as one-cycle strobes with their fields.
 * Assumes the bench calls send from its sequence; changes follow rising edges.
 */
`default_nettype none
module darr_dsi_master (
    // Clock.
    input wire logic hclk,
    // Decoded request.
    output logic req_valid,
    output darr_pkg::darr_req_type req
);
    timeunit 1ns;
    timeprecision 1ps;
    import darr_pkg::*;

    initial begin
        req_valid = 1'b0;
        req = '0;
    end

    task automatic send(input logic [3:0] cmd, input logic [3:0] addr, input logic [7:0] data,
                        input darr_fmt_type fmt, input logic [4:0] len);
        @(posedge hclk);
        req_valid <= 1'b1;
        req <= '{data: data, addr: addr, cmd: cmd, fmt: fmt, len: len};
        @(posedge hclk);
        req_valid <= 1'b0;
        // Stale fields are inverted so that nothing can lean on them.
        req <= darr_req_type'(~req);
    endtask
endmodule // darr_dsi_master
`default_nettype wire

// File: darr_responder_test.sv
/*
 * Self-checking bench for the acceleration read responder.
 * Assumes the bus master model drives requests and AHB-Lite reaches registers.
 */
`default_nettype none
`define CHECK_EQ(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; $display("mismatch %s expected %h seen %h", n, e, g); end end
module darr_responder_test;
    timeunit 1ns;
    timeprecision 1ps;
    import darr_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rsp_valid, req_valid;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] psa;
    logic [9:0] smp [4] = '{10'h003, 10'h001, 10'h000, 10'h3ff};
    darr_req_type req;
    darr_rsp_type rsp, got;
    int miscompares, compares, got_cnt;

    assign hready = hreadyout;

    darr_responder DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .req_valid(req_valid),
        .req(req), .rsp_valid(rsp_valid), .rsp(rsp), .programmed_slave_address(psa));

    darr_dsi_master dsi (.hclk(hclk), .req_valid(req_valid), .req(req));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        if (rsp_valid === 1'b1) begin
            got_cnt = got_cnt + 1;
            got = rsp;
        end
    end

    task automatic stop_test();
        if (miscompares == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] e, input string n);
        ahb(1'b0, a, 32'h0);
        `CHECK_EQ(n, e, rd)
        `CHECK_EQ("response", 1'b0, hresp)
    endtask

    task automatic rq(input logic [3:0] c, input logic [3:0] a, input logic [7:0] d,
                      input darr_fmt_type f, input logic [4:0] l, input int ans,
                      input logic [15:0] b);
        int c0;
        c0 = got_cnt;
        dsi.send(c, a, d, f, l);
        repeat (3) @(posedge hclk);
        `CHECK_EQ("answers", ans, got_cnt - c0)
        if (ans == 1) begin
            `CHECK_EQ("bits", b, got.bits)
            `CHECK_EQ("len", (f == DARR_STD_LONG || f == DARR_ENH_LONG) ? LEN_LONG : l, got.len)
        end
    endtask

    // Short response word, from sample, error, self-test, attributes and length.
    function automatic logic [15:0] exp_short(logic [9:0] s, logic e, logic t, logic [1:0] at,
                                              int n);
        logic [15:0] w;
        if (n == 8) w = (s[9:2] == 8'h0 && s != 10'h0) ? 16'h1 : {8'h0, s[9:2]};
        else if (n == 9) w = (s[9:1] == 9'h0 && s != 10'h0) ? 16'h1 : {7'h0, s[9:1]};
        else w = {1'b0, at[1], at[0], t, 1'b0, e, s} & ((16'h1 << n) - 16'h1);
        return w;
    endfunction

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        miscompares = 0;
        compares = 0;
        got_cnt = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(REG_CTRL, CTRL_RESET, "ctrl");
        rchk(REG_CFG, CFG_RESET, "config");
        rchk(REG_ACC, ACC_RESET, "sample");
        rchk(32'h20, 32'h0, "unmapped");
        rq(CMD_ACCEL, ADDR_GLOBAL, 8'h00, DARR_STD_LONG, LEN_LONG, 0, 16'h0);
        dsi.send(CMD_INIT, ADDR_GLOBAL, 8'h00, DARR_STD_LONG, LEN_LONG);
        repeat (2) @(posedge hclk);
        `CHECK_EQ("address", 4'h0, psa)
        dsi.send(CMD_INIT, 4'h5, 8'h00, DARR_STD_LONG, LEN_LONG);
        repeat (2) @(posedge hclk);
        `CHECK_EQ("address", 4'h5, psa)
        rq(CMD_ACCEL, 4'h5, 8'h00, DARR_STD_LONG, LEN_LONG, 1, 16'h5200);
        ahb(1'b1, REG_ACC, 32'h2a5);
        ahb(1'b1, REG_CTRL, 32'h2);
        rq(CMD_ACCEL, 4'h5, 8'h00, DARR_STD_LONG, LEN_LONG, 1, 16'h56a5);
        rq(CMD_ACCEL, 4'h5, 8'hff, DARR_STD_LONG, LEN_LONG, 1, 16'h56a5);
        rchk(REG_LAST, {11'h0, LEN_LONG, 16'h56a5}, "last");
        ahb(1'b1, REG_LAST, 32'h0);
        rchk(REG_LAST, {11'h0, LEN_LONG, 16'h56a5}, "last");
        rq(CMD_ACCEL, 4'h6, 8'h00, DARR_STD_LONG, LEN_LONG, 0, 16'h0);
        rq(CMD_UNIMPL, 4'h5, 8'h00, DARR_STD_SHORT, LEN_SHORT8, 0, 16'h0);
        rq(CMD_ACCEL, 4'h5, 8'h00, DARR_ENH_SHORT, LEN_SHORT8, 0, 16'h0);
        ahb(1'b1, REG_CTRL, 32'h7);
        ahb(1'b1, REG_CFG, 32'h2);
        rq(CMD_ACCEL, 4'h5, 8'h00, DARR_ENH_LONG, LEN_LONG, 1, 16'h56a5);
        for (int n = 8; n < 16; n++) begin
            rq(CMD_ACCEL, 4'h5, 8'h3c, (n % 2 == 1) ? DARR_ENH_SHORT : DARR_STD_SHORT, 5'(n), 1,
               exp_short(10'h2a5, 1'b1, 1'b1, 2'h2, n));
        end
        for (int i = 0; i < 4; i++) begin
            ahb(1'b1, REG_ACC, {22'h0, smp[i]});
            rq(CMD_ACCEL, 4'h5, 8'h00, DARR_STD_SHORT, LEN_SHORT8, 1,
               exp_short(smp[i], 1'b1, 1'b1, 2'h2, 8));
            rq(CMD_ACCEL, 4'h5, 8'h00, DARR_STD_SHORT, LEN_SHORT9, 1,
               exp_short(smp[i], 1'b1, 1'b1, 2'h2, 9));
        end
        // A reset in mid-run leaves the device unaddressed with the nominal sample.
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        `CHECK_EQ("address", 4'h0, psa)
        rchk(REG_ACC, ACC_RESET, "sample");
        rq(CMD_ACCEL, 4'h5, 8'h00, DARR_STD_LONG, LEN_LONG, 0, 16'h0);
        stop_test();
    end

    initial begin
        repeat (5000) @(posedge hclk);
        miscompares++;
        stop_test();
    end
endmodule // darr_responder_test
`default_nettype wire
